// ---- common/lhc_pkg.sv ----
`default_nettype none
package lhc_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam logic [AW-1:0] SET_OFS   = 8'h50;
  localparam logic [AW-1:0] CLEAR_OFS = 8'h54;
  localparam int unsigned SWAP_BIT   = 30;
  localparam int unsigned OWNER_BIT  = 23;
  localparam int unsigned ENH_BIT    = 22;
  localparam int unsigned POWER_BIT  = 19;
  localparam int unsigned POST_BIT   = 18;
  localparam int unsigned ATTACH_BIT = 17;
  localparam int unsigned REINIT_BIT = 16;
  localparam logic [DW-1:0] SETTABLE_MASK = 32'h404E0000;
  localparam logic [DW-1:0] CLEARABLE_MASK = 32'h40CE0000;
  localparam logic [DW-1:0] UNMAPPED_DATA = 32'h00000000;
  localparam logic SWAP_RST = 1'b0;
  localparam logic POST_RST = 1'b0;
  localparam int unsigned REINIT_NS = 1000;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned REINIT_CYC = (REINIT_NS + CLK_NS - 1) / CLK_NS;
  typedef struct packed {
    logic data_swap_disable;
    logic phy_config_owner_flag;
    logic phy_enhancement_on;
    logic link_power_state;
    logic write_posting_on;
    logic link_attach;
    logic local_reinit;
  } lhc_ctrl_type;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_REINIT = 2'b10
  } lhc_state_type;
endpackage
`default_nettype wire

// ---- rtl/lhc_link_host_control_register.sv ----
// Local design decision: the Avalon-MM slave port.
`default_nettype none
module lhc_link_host_control_register #(
  parameter int unsigned REINIT_CYCLES = lhc_pkg::REINIT_CYC
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_nrst,
  input  wire logic [lhc_pkg::AW-1:0] i_address,
  input  wire logic                   i_read,
  input  wire logic                   i_write,
  input  wire logic [lhc_pkg::DW-1:0] i_writedata,
  input  wire logic [3:0]             i_byteenable,
  input  wire logic                   i_eeprom_valid,
  input  wire logic                   i_eeprom_owner,
  output logic [lhc_pkg::DW-1:0]      o_readdata,
  output logic                        o_waitrequest,
  output logic                        o_data_swap_en,
  output logic                        o_phy_enhancement_on,
  output logic                        o_link_phy_allowed,
  output logic                        o_write_posting_on,
  output logic                        o_link_attached,
  output logic                        o_link_reinit
);

  // ************************************************************
  // bus slave
  // ************************************************************
  lhc_pkg::lhc_ctrl_type ctrl;
  lhc_pkg::lhc_state_type state;
  logic [15:0] reinit_cnt;
  logic [15:0] reinit_seen;
  logic        ack;
  logic        eeprom_s1;
  logic        eeprom_s2;
  logic        owner_s1;
  logic        owner_s2;
  logic [lhc_pkg::DW-1:0] wmask;
  logic [lhc_pkg::DW-1:0] cur;
  logic        wr_set;
  logic        wr_clr;

  // one wait cycle: every access answers on the second edge
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_read || i_write) && !ack;
    end
  end
  assign o_waitrequest = (i_read || i_write) && !ack;

  always_comb begin
    wmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
             {8{i_byteenable[1]}}, {8{i_byteenable[0]}}} & i_writedata;
  end

  assign wr_set = i_write && ack && (i_address == lhc_pkg::SET_OFS);
  assign wr_clr = i_write && ack && (i_address == lhc_pkg::CLEAR_OFS);

  always_comb begin
    cur = '0;
    cur[lhc_pkg::SWAP_BIT]   = ctrl.data_swap_disable;
    cur[lhc_pkg::OWNER_BIT]  = ctrl.phy_config_owner_flag;
    cur[lhc_pkg::ENH_BIT]    = ctrl.phy_enhancement_on;
    cur[lhc_pkg::POWER_BIT]  = ctrl.link_power_state;
    cur[lhc_pkg::POST_BIT]   = ctrl.write_posting_on;
    cur[lhc_pkg::ATTACH_BIT] = ctrl.link_attach;
    cur[lhc_pkg::REINIT_BIT] = ctrl.local_reinit;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_readdata <= lhc_pkg::UNMAPPED_DATA;
    end else if (i_read && !ack) begin
      if (i_address == lhc_pkg::SET_OFS || i_address == lhc_pkg::CLEAR_OFS) begin
        o_readdata <= cur;
      end else begin
        o_readdata <= lhc_pkg::UNMAPPED_DATA;
      end
    end
  end

  // ************************************************************
  // eeprom strap sync
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      eeprom_s1 <= 1'b0;
      eeprom_s2 <= 1'b0;
      owner_s1  <= 1'b0;
      owner_s2  <= 1'b0;
    end else begin
      eeprom_s1 <= i_eeprom_valid;
      eeprom_s2 <= eeprom_s1;
      owner_s1  <= i_eeprom_owner;
      owner_s2  <= owner_s1;
    end
  end

  // ************************************************************
  // control bits
  // ************************************************************
  // the reinit sequence returns the link bits to hardware defaults but the
  // owner flag is an eeprom strap and survives it
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl.data_swap_disable     <= lhc_pkg::SWAP_RST;
      ctrl.phy_config_owner_flag <= 1'b0;
      ctrl.phy_enhancement_on    <= 1'b0;
      ctrl.link_power_state      <= 1'b0;
      ctrl.write_posting_on      <= lhc_pkg::POST_RST;
      ctrl.link_attach           <= 1'b0;
      ctrl.local_reinit          <= 1'b0;
    end else if (state == lhc_pkg::ST_REINIT) begin
      ctrl.data_swap_disable  <= lhc_pkg::SWAP_RST;
      ctrl.phy_enhancement_on <= 1'b0;
      ctrl.link_power_state   <= 1'b0;
      ctrl.write_posting_on   <= lhc_pkg::POST_RST;
      ctrl.link_attach        <= 1'b0;
      // clear writes cannot cut a reinit short: hardware owns this bit
      ctrl.local_reinit       <= (reinit_cnt != '0);
      if (wr_clr && wmask[lhc_pkg::OWNER_BIT]) begin
        ctrl.phy_config_owner_flag <= 1'b0;
      end
    end else begin
      ctrl.local_reinit <= wr_set && wmask[lhc_pkg::REINIT_BIT];
      if (eeprom_s2) begin
        ctrl.phy_config_owner_flag <= owner_s2;
      end else if (wr_clr && wmask[lhc_pkg::OWNER_BIT]) begin
        ctrl.phy_config_owner_flag <= 1'b0;
      end
      if (wr_set && wmask[lhc_pkg::SWAP_BIT]) begin
        ctrl.data_swap_disable <= 1'b1;
      end else if (wr_clr && wmask[lhc_pkg::SWAP_BIT]) begin
        ctrl.data_swap_disable <= 1'b0;
      end
      // guard keeps a careless driver from enabling without ownership
      if (wr_set && wmask[lhc_pkg::ENH_BIT]
          && ctrl.phy_config_owner_flag && ctrl.link_attach) begin
        ctrl.phy_enhancement_on <= 1'b1;
      end else if (wr_clr && wmask[lhc_pkg::ENH_BIT]) begin
        ctrl.phy_enhancement_on <= 1'b0;
      end
      if (wr_set && wmask[lhc_pkg::POWER_BIT]) begin
        ctrl.link_power_state <= 1'b1;
      end else if (wr_clr && wmask[lhc_pkg::POWER_BIT]) begin
        ctrl.link_power_state <= 1'b0;
      end
      if (wr_set && wmask[lhc_pkg::POST_BIT]) begin
        ctrl.write_posting_on <= 1'b1;
      end else if (wr_clr && wmask[lhc_pkg::POST_BIT]) begin
        ctrl.write_posting_on <= 1'b0;
      end
      if (wr_set && wmask[lhc_pkg::ATTACH_BIT]) begin
        ctrl.link_attach <= 1'b1;
      end else if (wr_clr && wmask[lhc_pkg::ATTACH_BIT]) begin
        ctrl.link_attach <= 1'b0;
      end
    end
  end

  // ************************************************************
  // reinit sequencer
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state      <= lhc_pkg::ST_IDLE;
      reinit_cnt <= '0;
    end else begin
      case (state)
        lhc_pkg::ST_IDLE: begin
          if (wr_set && wmask[lhc_pkg::REINIT_BIT]) begin
            state      <= lhc_pkg::ST_REINIT;
            reinit_cnt <= 16'(REINIT_CYCLES - 1);
          end
        end
        lhc_pkg::ST_REINIT: begin
          if (reinit_cnt == '0) begin
            state <= lhc_pkg::ST_IDLE;
          end else begin
            reinit_cnt <= reinit_cnt - 16'h0001;
          end
        end
        default: begin
          state <= lhc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // reinit length monitor
  // ************************************************************
  // counts cycles spent in reinit so the length check needs no long repetition
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      reinit_seen <= '0;
    end else if (ctrl.local_reinit) begin
      reinit_seen <= reinit_seen + 16'h0001;
    end else begin
      reinit_seen <= '0;
    end
  end

  // ************************************************************
  // link side controls
  // ************************************************************
  assign o_data_swap_en       = !ctrl.data_swap_disable;
  assign o_phy_enhancement_on = ctrl.phy_enhancement_on;
  assign o_link_phy_allowed   = ctrl.link_power_state && !ctrl.local_reinit;
  assign o_write_posting_on   = ctrl.write_posting_on;
  assign o_link_attached      = ctrl.link_attach && !ctrl.local_reinit;
  assign o_link_reinit        = ctrl.local_reinit;

  // ************************************************************
  // checks
  // ************************************************************
  // checks look one step ahead except owner_noset_a, enh_guard_a and reinit_len_a, which use |->; long spans go through a helper counter
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  wait_once_a: assert property (
    (i_read || i_write) && !ack |=> !o_waitrequest)
    else $error("waitrequest held past one cycle");

  set_attach_a: assert property (
    wr_set && wmask[lhc_pkg::ATTACH_BIT] && !wmask[lhc_pkg::REINIT_BIT]
      && state == lhc_pkg::ST_IDLE |=> o_link_attached)
    else $error("attach did not set");

  clear_power_a: assert property (
    wr_clr && wmask[lhc_pkg::POWER_BIT] && !wr_set |=> !o_link_phy_allowed)
    else $error("power state did not clear");

  reserved_zero_a: assert property (
    ack && i_read |=> (o_readdata & ~lhc_pkg::CLEARABLE_MASK
      & ~(32'h00000001 << lhc_pkg::REINIT_BIT)) == '0)
    else $error("reserved bit read nonzero");

  unmapped_read_a: assert property (
    i_read && !ack && i_address != lhc_pkg::SET_OFS && i_address != lhc_pkg::CLEAR_OFS
      |=> o_readdata == lhc_pkg::UNMAPPED_DATA)
    else $error("unmapped read not zero");

  swap_clear_a: assert property (
    wr_clr && wmask[lhc_pkg::SWAP_BIT] |=> o_data_swap_en)
    else $error("swap control did not clear");

  owner_noset_a: assert property (
    $rose(ctrl.phy_config_owner_flag) |-> $past(eeprom_s2))
    else $error("owner flag set by software");

  owner_load_a: assert property (
    eeprom_s2 && !ctrl.local_reinit |=> ctrl.phy_config_owner_flag == $past(owner_s2))
    else $error("owner flag did not follow strap");

  owner_clear_a: assert property (
    wr_clr && wmask[lhc_pkg::OWNER_BIT] && !eeprom_s2 |=> !ctrl.phy_config_owner_flag)
    else $error("owner flag did not clear");

  owner_keep_a: assert property (
    ctrl.local_reinit && !wr_clr |=> $stable(ctrl.phy_config_owner_flag))
    else $error("owner flag lost in reinit");

  enh_guard_a: assert property (
    $rose(ctrl.phy_enhancement_on) |-> $past(ctrl.phy_config_owner_flag && ctrl.link_attach))
    else $error("enhancement set without ownership");

  enh_set_a: assert property (
    wr_set && wmask[lhc_pkg::ENH_BIT] && ctrl.phy_config_owner_flag && ctrl.link_attach
      && !ctrl.local_reinit |=> o_phy_enhancement_on)
    else $error("enhancement set refused");

  power_on_a: assert property (
    wr_set && wmask[lhc_pkg::POWER_BIT] && !wmask[lhc_pkg::REINIT_BIT]
      && !ctrl.local_reinit |=> o_link_phy_allowed)
    else $error("power state did not set");

  posting_a: assert property (
    wr_set && wmask[lhc_pkg::POST_BIT] && !ctrl.local_reinit |=> o_write_posting_on)
    else $error("posting did not set");

  posting_hold_a: assert property (
    !wr_set && !wr_clr && !ctrl.local_reinit |=> $stable(ctrl.write_posting_on))
    else $error("posting changed without a write");

  reinit_drop_a: assert property (
    $rose(ctrl.local_reinit) |=> !ctrl.link_attach)
    else $error("attach survived reinit");

  detached_a: assert property (
    wr_clr && wmask[lhc_pkg::ATTACH_BIT] |=> !o_link_attached)
    else $error("link attached while disabled");

  reinit_start_a: assert property (
    wr_set && wmask[lhc_pkg::REINIT_BIT] && !ctrl.local_reinit |=> o_link_reinit)
    else $error("reinit did not start");

  reinit_flush_a: assert property (
    $rose(ctrl.local_reinit) |=> ctrl.write_posting_on == lhc_pkg::POST_RST
      && !ctrl.link_power_state && !ctrl.phy_enhancement_on
      && ctrl.data_swap_disable == lhc_pkg::SWAP_RST)
    else $error("reinit left link bits set");

  reinit_read_a: assert property (
    i_read && !ack && ctrl.local_reinit && i_address == lhc_pkg::SET_OFS
      |=> o_readdata[lhc_pkg::REINIT_BIT])
    else $error("reinit bit not read as one");

  readback_a: assert property (
    i_read && !ack && i_address == lhc_pkg::CLEAR_OFS |=> o_readdata == $past(cur))
    else $error("readback mismatch");

  set_readback_a: assert property (
    i_read && !ack && i_address == lhc_pkg::SET_OFS |=> o_readdata == $past(cur))
    else $error("set port readback mismatch");

  reinit_len_a: assert property (
    $fell(ctrl.local_reinit) |-> reinit_seen == 16'(REINIT_CYCLES))
    else $error("reinit length wrong");

  // ************************************************************
  // cover points
  // ************************************************************
  reinit_c: cover property ($fell(ctrl.local_reinit));
  enh_c: cover property ($rose(ctrl.phy_enhancement_on));
  attach_c: cover property ($rose(o_link_attached) ##[1:20] o_link_phy_allowed);
  owner_load_c: cover property ($rose(ctrl.phy_config_owner_flag));
  unmapped_c: cover property (i_read && ack && i_address != lhc_pkg::SET_OFS
    && i_address != lhc_pkg::CLEAR_OFS);

endmodule // lhc_link_host_control_register
`default_nettype wire

// ---- verification/lhc_link_host_control_register_tb.sv ----
`default_nettype none
module lhc_link_host_control_register_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************
  // signals and design
  // ********************************
  logic                   i_mclk = 1'b0;
  logic                   i_nrst = 1'b0;
  logic [lhc_pkg::AW-1:0] i_address = '0;
  logic                   i_read = 1'b0;
  logic                   i_write = 1'b0;
  logic [lhc_pkg::DW-1:0] i_writedata = '0;
  logic [3:0]             i_byteenable = 4'h0;
  logic                   i_eeprom_valid = 1'b0;
  logic                   i_eeprom_owner = 1'b0;
  logic [lhc_pkg::DW-1:0] o_readdata;
  logic                   o_waitrequest;
  logic                   o_data_swap_en;
  logic                   o_phy_enhancement_on;
  logic                   o_link_phy_allowed;
  logic                   o_write_posting_on;
  logic                   o_link_attached;
  logic                   o_link_reinit;
  logic [lhc_pkg::DW-1:0] d;
  int                     fail_count = 0;
  int                     checks = 0;
  int                     n;
  always #25 i_mclk = ~i_mclk;
  // short reinit keeps the run brief; margin left so mid-reinit samples still land
  localparam int REINIT_LEN = 6;
  lhc_link_host_control_register #(.REINIT_CYCLES(REINIT_LEN)) dut_u (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .i_eeprom_valid(i_eeprom_valid), .i_eeprom_owner(i_eeprom_owner),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_data_swap_en(o_data_swap_en), .o_phy_enhancement_on(o_phy_enhancement_on),
    .o_link_phy_allowed(o_link_phy_allowed), .o_write_posting_on(o_write_posting_on),
    .o_link_attached(o_link_attached), .o_link_reinit(o_link_reinit)
  );
  // ********************************
  // tasks
  // ********************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon access; an edge passes after release so strobes never retoggle in one step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    i_address <= a;
    i_writedata <= wd;
    i_byteenable <= be;
    i_write <= wr;
    i_read <= ~wr;
    do begin
      @(posedge i_mclk);
    end while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] dummy;
    bus(1'b1, a, wd, be, dummy);
  endtask
  function automatic logic [31:0] outs();
    return {26'h0, o_data_swap_en, o_phy_enhancement_on, o_link_phy_allowed,
            o_write_posting_on, o_link_attached, o_link_reinit};
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ********************************
  // tests
  // ********************************
  initial begin
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    bus(1'b0, lhc_pkg::SET_OFS, 32'h0, 4'hF, d);
    check(d, 32'h00000000);
    check(outs(), 32'h20);
    // owner bit cannot be set from the bus; enhancement left alone while not owner
    wr(lhc_pkg::SET_OFS, 32'hFFBEFFFF, 4'hF);
    bus(1'b0, lhc_pkg::CLEAR_OFS, 32'h0, 4'hF, d);
    check(d, 32'h400E0000);
    check(outs(), 32'h0E);
    i_eeprom_owner <= 1'b1;
    i_eeprom_valid <= 1'b1;
    repeat (5) @(posedge i_mclk);
    i_eeprom_valid <= 1'b0;
    @(posedge i_mclk);
    bus(1'b0, lhc_pkg::SET_OFS, 32'h0, 4'hF, d);
    check(d, 32'h408E0000);
    wr(lhc_pkg::SET_OFS, 32'h00400000, 4'hF);
    bus(1'b0, lhc_pkg::SET_OFS, 32'h0, 4'hF, d);
    check(d, 32'h40CE0000);
    check(outs(), 32'h1E);
    wr(lhc_pkg::CLEAR_OFS, 32'h00800000, 4'hF);
    bus(1'b0, lhc_pkg::SET_OFS, 32'h0, 4'hF, d);
    check(d, 32'h404E0000);
    // only lane 3 enabled: bit 30 clears, bit 22 survives
    wr(lhc_pkg::CLEAR_OFS, 32'hFFFFFFFF, 4'h8);
    bus(1'b0, lhc_pkg::CLEAR_OFS, 32'h0, 4'hF, d);
    check(d, 32'h004E0000);
    check(outs(), 32'h3E);
    wr(lhc_pkg::SET_OFS, 32'h00010000, 4'hF);
    check(outs(), 32'h35);
    bus(1'b0, lhc_pkg::SET_OFS, 32'h0, 4'hF, d);
    check({31'h0, d[16]}, 32'h1);
    n = 0;
    while (o_link_reinit !== 1'b0 && n < 12) begin
      @(posedge i_mclk);
      n++;
    end
    check({31'h0, o_link_reinit}, 32'h0);
    // the read and its release already used three of the reinit cycles
    check(n, REINIT_LEN - 3);
    bus(1'b0, lhc_pkg::SET_OFS, 32'h0, 4'hF, d);
    check(d, 32'h00000000);
    check(outs(), 32'h20);
    wr(8'h58, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, 8'h58, 32'h0, 4'hF, d);
    check(d, 32'h00000000);
    bus(1'b0, lhc_pkg::CLEAR_OFS, 32'h0, 4'hF, d);
    check(d, 32'h00000000);
    wr(lhc_pkg::SET_OFS, 32'h000A0000, 4'hF);
    check(outs(), 32'h2A);
    wr(lhc_pkg::CLEAR_OFS, 32'h00020000, 4'hF);
    check(outs(), 32'h28);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    check(outs(), 32'h20);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    bus(1'b0, lhc_pkg::SET_OFS, 32'h0, 4'hF, d);
    check(d, 32'h00000000);
    stop_test();
  end
  // roughly twenty accesses of a few cycles each; ample headroom
  initial begin
    repeat (3000) @(posedge i_mclk);
    fail_count++;
    stop_test();
  end
endmodule // lhc_link_host_control_register_tb
`default_nettype wire
